/* rtl/str_top.sv */
// Serial temperature readout: link slave, configuration and result registers
`timescale 1ns/1ps
// Notes on behaviour
// - Link type select high gives four-wire link, low gives three-wire link.
// - Three-wire mode shares one data line; device drives it only for read data.
// - Power-up state is shutdown with no conversions until configured.
// - Continuous mode converts repeatedly, storing each result at 01h/02h.
// - Reading results never disturbs a running conversion.
// - One-shot does one conversion, stores it, returns to shutdown.
// - Resolution selectable 8 to 12 bits, default 9 bits.
// - Conversion time doubles per extra bit of resolution.
// - Results stored as two's complement across two bytes.
// - Unused low result bits forced to zero below 12 bits.
// - Bytes sent MSB first on four-wire link, LSB first on three-wire.
// - High byte sign and integer bits; low byte fraction in 7:4, zeros 3:0.
// - Shutdown during continuous mode finishes and stores current conversion.
// - Single-conversion bit works only in shutdown and self-clears on completion.
// - Top resolution bit selects 12 bits; otherwise low bits pick 8 to 11.
// - Configuration read at 00h, written at 80h; results read-only.
module str_top #(
  parameter int CONV_BASE_CYCLES = str_pkg::CONV_8BIT_CYCLES
) (
  // Core clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Link pins, serial clock from host
  input wire logic i_link_sclk,
  input wire logic i_chip_enable,
  input wire logic i_link_type_select,
  input wire logic i_serial_in_pin,
  output logic o_serial_out_pin,
  output logic o_serial_out_oe,
  // Temperature sample from the sensor front end, 12-bit two's complement, 1/16 degree
  input wire logic [11:0] i_sensor_temp,
  // Status
  output logic o_converting
);
  // ---------------- Core domain ----------------
  logic [7:0] cfg_reg;
  logic [7:0] temp_lo_reg;
  logic [7:0] temp_hi_reg;
  logic cont_run_reg;
  logic oneshot_run_reg;
  logic conv_start;
  logic conv_busy;
  logic conv_done;
  logic [2:0] res_sel;
  logic [11:0] masked_temp;
  logic [11:0] res_mask;
  logic wr_tgl_sync;
  logic wr_tgl_seen_reg;
  logic wr_event;
  logic [7:0] wr_data_hold;
  logic mode_sync;
  logic ce_sync;
  logic [7:0] shadow_cfg_reg;
  logic [7:0] shadow_lo_reg;
  logic [7:0] shadow_hi_reg;

  // Link-domain signals
  logic ce_l;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_in_reg;
  logic [7:0] addr_reg;
  logic addr_done_reg;
  logic [7:0] tx_reg;
  logic tx_active_reg;
  logic [7:0] wr_data_reg;
  logic wr_tgl_reg;
  logic [7:0] snap_cfg_reg;
  logic [7:0] snap_lo_reg;
  logic [7:0] snap_hi_reg;
  logic [7:0] rx_byte;
  logic [7:0] rd_byte;
  logic [7:0] next_addr;
  logic lsb_first;
  logic data_in;

  // Link type is a strap; it is only sampled through a synchroniser
  str_sync u_mode_sync (
    .i_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_d(i_link_type_select),
    .o_q(mode_sync)
  );

  str_sync u_wr_sync (
    .i_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_d(wr_tgl_reg),
    .o_q(wr_tgl_sync)
  );

  // Chip enable seen by the core, to freeze the copy that the link reads
  str_sync u_ce_sync (
    .i_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_d(i_chip_enable),
    .o_q(ce_sync)
  );

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_tgl_seen_reg <= 1'b0;
    end else begin
      wr_tgl_seen_reg <= wr_tgl_sync;
    end
  end
  assign wr_event = wr_tgl_sync ^ wr_tgl_seen_reg;
  // Write data is stable in the link domain well before the toggle arrives
  assign wr_data_hold = wr_data_reg;

  assign res_sel = cfg_reg[str_pkg::CFG_RES_HI:str_pkg::CFG_RES_LO];

  // Powers up in shutdown, 9-bit, single-conversion clear
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_reg <= str_pkg::CFG_RESET;
    end else begin
      if (wr_event) begin
        cfg_reg[str_pkg::CFG_SHUTDOWN_BIT] <= wr_data_hold[str_pkg::CFG_SHUTDOWN_BIT];
        cfg_reg[str_pkg::CFG_RES_HI:str_pkg::CFG_RES_LO] <=
          wr_data_hold[str_pkg::CFG_RES_HI:str_pkg::CFG_RES_LO];
        // Single bit accepted only while shutdown stays set
        if (cfg_reg[str_pkg::CFG_SHUTDOWN_BIT] && wr_data_hold[str_pkg::CFG_SHUTDOWN_BIT]) begin
          cfg_reg[str_pkg::CFG_SINGLE_BIT] <= wr_data_hold[str_pkg::CFG_SINGLE_BIT] |
            cfg_reg[str_pkg::CFG_SINGLE_BIT];
        end
      end
      // Completion clears it; a concurrent write cannot re-arm a finished shot
      if (conv_done && oneshot_run_reg) begin
        cfg_reg[str_pkg::CFG_SINGLE_BIT] <= 1'b0;
      end
      cfg_reg[7:5] <= str_pkg::CFG_FIXED_ONES[7:5];
    end
  end

  // Continuous runs while shutdown clear; a running one finishes first
  assign conv_start = !conv_busy && !conv_done &&
    (!cfg_reg[str_pkg::CFG_SHUTDOWN_BIT] || cfg_reg[str_pkg::CFG_SINGLE_BIT]);

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cont_run_reg <= 1'b0;
      oneshot_run_reg <= 1'b0;
    end else if (conv_start) begin
      cont_run_reg <= !cfg_reg[str_pkg::CFG_SHUTDOWN_BIT];
      oneshot_run_reg <= cfg_reg[str_pkg::CFG_SHUTDOWN_BIT];
    end else if (conv_done) begin
      cont_run_reg <= 1'b0;
      oneshot_run_reg <= 1'b0;
    end
  end

  // Conversion is core-only; link reads never touch it
  str_conv #(
    .BASE_CYCLES(CONV_BASE_CYCLES)
  ) u_conv (
    .i_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_start(conv_start),
    .i_res(res_sel),
    .o_busy(conv_busy),
    .o_done(conv_done)
  );

  // Mask fraction bits below the chosen resolution
  always_comb begin
    unique case ({res_sel[2], res_sel[1:0]} & {1'b1, {2{~res_sel[2]}}})
      3'h0: res_mask = 12'hFF0;
      3'h1: res_mask = 12'hFF8;
      3'h2: res_mask = 12'hFFC;
      3'h3: res_mask = 12'hFFE;
      default: res_mask = 12'hFFF;
    endcase
    masked_temp = i_sensor_temp & res_mask;
  end

  // Both bytes land in the same cycle, two's complement layout
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      temp_lo_reg <= 8'h00;
      temp_hi_reg <= 8'h00;
    end else if (conv_done) begin
      temp_hi_reg <= masked_temp[11:4];
      temp_lo_reg <= {masked_temp[3:0], 4'h0};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_converting <= 1'b0;
    end else begin
      o_converting <= conv_busy;
    end
  end

  // Core-side copy for the link, frozen while chip enable is high so that no
  // register changes under a frame; the host keeps chip enable steady for two
  // core cycles before each frame for the freeze to take hold
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shadow_cfg_reg <= str_pkg::CFG_RESET;
      shadow_lo_reg <= 8'h00;
      shadow_hi_reg <= 8'h00;
    end else if (!ce_sync) begin
      shadow_cfg_reg <= cfg_reg;
      shadow_lo_reg <= temp_lo_reg;
      shadow_hi_reg <= temp_hi_reg;
    end
  end

  // ---------------- Link domain (serial clock) ----------------
  // Chip enable gates all link activity; it also resets the link asynchronously
  assign ce_l = i_chip_enable & i_arst_n;
  // Three-wire uses the serial input as the shared line's receive side
  assign data_in = i_serial_in_pin;
  // Strap through the core synchroniser; it settles long before a frame starts
  assign lsb_first = !mode_sync;
  assign rx_byte = lsb_first ? {data_in, shift_in_reg[7:1]} : {shift_in_reg[6:0], data_in};

  // Byte to send, from the snapshot taken at the last byte boundary
  always_comb begin
    unique case (addr_reg)
      str_pkg::ADDR_CFG_RD: rd_byte = snap_cfg_reg;
      str_pkg::ADDR_TEMP_LO: rd_byte = snap_lo_reg;
      str_pkg::ADDR_TEMP_HI: rd_byte = snap_hi_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    if (!addr_done_reg) begin
      next_addr = rx_byte;
    end else if (addr_reg[1:0] == 2'h2) begin
      next_addr = {addr_reg[7], 7'h00};
    end else begin
      next_addr = addr_reg + 8'h01;
    end
  end

  // Input latched on the rising edge
  always_ff @(posedge i_link_sclk or negedge ce_l) begin
    if (!ce_l) begin
      bit_cnt_reg <= 3'h0;
      shift_in_reg <= 8'h00;
      addr_reg <= 8'h00;
      addr_done_reg <= 1'b0;
      snap_cfg_reg <= 8'h00;
      snap_lo_reg <= 8'h00;
      snap_hi_reg <= 8'h00;
    end else begin
      shift_in_reg <= rx_byte;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == 3'h7) begin
        snap_cfg_reg <= shadow_cfg_reg;
        snap_lo_reg <= shadow_lo_reg;
        snap_hi_reg <= shadow_hi_reg;
        if (!addr_done_reg) begin
          addr_done_reg <= 1'b1;
          addr_reg <= rx_byte;
        end else begin
          addr_reg <= next_addr;
        end
      end
    end
  end

  // Write hand-off to the core; kept out of the chip enable reset so that the
  // toggle and its data outlive the frame until the core has taken them
  always_ff @(posedge i_link_sclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_data_reg <= 8'h00;
      wr_tgl_reg <= 1'b0;
    end else if (bit_cnt_reg == 3'h7 && addr_done_reg && addr_reg == str_pkg::ADDR_CFG_WR) begin
      // Only 80h writes; result addresses are read-only
      wr_data_reg <= rx_byte;
      wr_tgl_reg <= ~wr_tgl_reg;
    end
  end

  // Output shifted on the falling edge, driven only during read data
  always_ff @(negedge i_link_sclk or negedge ce_l) begin
    if (!ce_l) begin
      tx_reg <= 8'h00;
      tx_active_reg <= 1'b0;
      o_serial_out_pin <= 1'b0;
      o_serial_out_oe <= 1'b0;
    end else if (bit_cnt_reg == 3'h0 && addr_done_reg) begin
      tx_active_reg <= !addr_reg[7];
      o_serial_out_oe <= !addr_reg[7];
      o_serial_out_pin <= lsb_first ? rd_byte[0] : rd_byte[7];
      tx_reg <= lsb_first ? {1'b0, rd_byte[7:1]} : {rd_byte[6:0], 1'b0};
    end else if (tx_active_reg) begin
      o_serial_out_pin <= lsb_first ? tx_reg[0] : tx_reg[7];
      tx_reg <= lsb_first ? {1'b0, tx_reg[7:1]} : {tx_reg[6:0], 1'b0};
    end
  end

endmodule

/* rtl/str_pkg.sv */
// Shared constants for the serial temperature readout block
package str_pkg;
  localparam logic [7:0] ADDR_CFG_RD = 8'h00;
  localparam logic [7:0] ADDR_TEMP_LO = 8'h01;
  localparam logic [7:0] ADDR_TEMP_HI = 8'h02;
  localparam logic [7:0] ADDR_CFG_WR = 8'h80;
  localparam int CFG_SHUTDOWN_BIT = 0;
  localparam int CFG_RES_LO = 1;
  localparam int CFG_RES_HI = 3;
  localparam int CFG_SINGLE_BIT = 4;
  localparam logic [7:0] CFG_RESET = 8'hE3;
  localparam logic [7:0] CFG_FIXED_ONES = 8'hE0;
  localparam logic [2:0] RES_DEFAULT = 3'h1;
  localparam int CLK_HZ = 40000000;
  // Maximum conversion time at 8 bits, in microseconds
  localparam int CONV_8BIT_US = 75000;
  localparam int CONV_8BIT_CYCLES = (CLK_HZ / 1000000) * CONV_8BIT_US;
  localparam int CONV_CNT_W = 26;
endpackage

/* rtl/str_sync.sv */
// Two-flop synchroniser for a single level
`timescale 1ns/1ps
module str_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Level
  input wire logic i_d,
  output logic o_q
);
  logic meta_reg;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_reg <= 1'b0;
      o_q <= 1'b0;
    end else begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end
endmodule

/* rtl/str_conv.sv */
// Conversion timer: runs one conversion of length scaled by resolution
`timescale 1ns/1ps
module str_conv #(
  parameter int BASE_CYCLES = str_pkg::CONV_8BIT_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Control
  input wire logic i_start,
  input wire logic [2:0] i_res,
  // Status
  output logic o_busy,
  output logic o_done
);
  logic [str_pkg::CONV_CNT_W-1:0] cnt_reg;
  logic [str_pkg::CONV_CNT_W-1:0] len;
  logic [2:0] shift;
  always_comb begin
    shift = i_res[2] ? 3'h4 : {1'b0, i_res[1:0]};
    // Each extra bit doubles the time
    len = str_pkg::CONV_CNT_W'(BASE_CYCLES) << shift;
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_reg <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (!o_busy && i_start) begin
        o_busy <= 1'b1;
        cnt_reg <= len - str_pkg::CONV_CNT_W'(1);
      end else if (o_busy) begin
        if (cnt_reg == '0) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - str_pkg::CONV_CNT_W'(1);
        end
      end
    end
  end
endmodule

/* verification/str_top_assertions.sv */
// Port checker for the serial temperature readout
`timescale 1ns/1ps
module str_top_chk #(
  parameter int CONV_BASE_CYCLES = 20
) (
  // Core
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Link
  input wire logic i_link_sclk,
  input wire logic i_chip_enable,
  input wire logic i_link_type_select,
  input wire logic i_serial_in_pin,
  input wire logic o_serial_out_pin,
  input wire logic o_serial_out_oe,
  // Sensor and status
  input wire logic [11:0] i_sensor_temp,
  input wire logic o_converting
);
  localparam int CONV_MIN = CONV_BASE_CYCLES - 2;
  logic [15:0] conv_cnt;
  logic [3:0] bit_cnt;
  logic first_bit;
  logic eighth_bit;
  logic wr_frame;
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      conv_cnt <= '0;
    end else begin
      conv_cnt <= o_converting ? conv_cnt + 16'h1 : 16'h0;
    end
  end
  // Bit position in the frame; the write flag sits first or eighth depending on bit order
  always_ff @(posedge i_link_sclk or negedge i_chip_enable or negedge i_arst_n) begin
    if (!i_chip_enable || !i_arst_n) begin
      bit_cnt <= '0;
      first_bit <= 1'b0;
      eighth_bit <= 1'b0;
    end else begin
      if (bit_cnt != 4'hF) bit_cnt <= bit_cnt + 4'h1;
      if (bit_cnt == 4'h0) first_bit <= i_serial_in_pin;
      if (bit_cnt == 4'h7) eighth_bit <= i_serial_in_pin;
    end
  end
  assign wr_frame = i_link_type_select ? first_bit : eighth_bit;
  chk_boot_idle: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    $rose(i_arst_n) |-> !o_converting [*8]) else $error("conversion started at boot");
  chk_conv_min: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    $fell(o_converting) |-> conv_cnt >= CONV_MIN) else $error("conversion ended early");
  chk_oe_rose_ce: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    $rose(o_serial_out_oe) |-> i_chip_enable) else $error("output driven while deselected");
  chk_oe_drop: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    $fell(i_chip_enable) |-> ##[1:3] !o_serial_out_oe) else $error("output kept after deselect");
  chk_ce_low_quiet: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    !i_chip_enable [*3] |-> !o_serial_out_oe) else $error("output driven while idle");
  chk_oe_after_addr: assert property (@(posedge i_link_sclk) disable iff (!i_arst_n || !i_chip_enable)
    o_serial_out_oe |-> bit_cnt >= 4'h8) else $error("output driven during address");
  chk_oe_not_write: assert property (@(posedge i_link_sclk) disable iff (!i_arst_n || !i_chip_enable)
    bit_cnt >= 4'h8 && wr_frame |-> !o_serial_out_oe) else $error("output driven in write");
  chk_read_drives: assert property (@(posedge i_link_sclk) disable iff (!i_arst_n || !i_chip_enable)
    bit_cnt == 4'h8 && !wr_frame |-> o_serial_out_oe) else $error("read data not driven");
  cov_conv_done: cover property (@(posedge i_core_clk) $fell(o_converting));
  cov_read: cover property (@(posedge i_link_sclk) bit_cnt == 4'h8 && !wr_frame);
  cov_back_to_back: cover property (@(posedge i_core_clk) $fell(o_converting) ##[1:4] o_converting);
endmodule
bind str_top str_top_chk #(.CONV_BASE_CYCLES(CONV_BASE_CYCLES)) i_chk (.i_core_clk, .i_arst_n, .i_link_sclk,
  .i_chip_enable, .i_link_type_select, .i_serial_in_pin, .o_serial_out_pin, .o_serial_out_oe,
  .i_sensor_temp, .o_converting);

/* verification/str_host_model.sv */
// Host model: serial bus master on the link pins
`timescale 1ns/1ps
module str_host_model (
  // Link pins
  output logic o_sclk,
  output logic o_ce,
  output logic o_sdi,
  // Line seen by the host and bit order strap
  input wire logic i_rx,
  input wire logic i_four_wire
);
  logic [7:0] rd [0:2];
  initial begin
    o_sclk = 1'b0;
    o_ce = 1'b0;
    o_sdi = 1'b0;
  end
  // A released line toggles every bit so stale data never passes for an answer
  task automatic xbyte(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
    int k;
    for (int i = 0; i < 8; i++) begin
      k = i_four_wire ? 7 - i : i;
      o_sdi = drv ? tx[k] : ~o_sdi;
      #3 o_sclk = 1'b1;
      rx[k] = i_rx;
      #3 o_sclk = 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] addr, input logic [7:0] wd, input int n);
    logic [7:0] junk;
    o_ce = 1'b1;
    // Chip enable stays steady for two core cycles before the first edge and drops 10 ns after the last
    #60 xbyte(addr, 1'b1, junk);
    for (int j = 0; j < n; j++) begin
      xbyte(wd, addr[7], rd[j]);
    end
    #10 o_ce = 1'b0;
    #150;
  endtask
endmodule

/* verification/str_top_tb.sv */
// Testbench for the serial temperature readout
`timescale 1ns/1ps
module str_top_tb;
  localparam int BASE = 20;
  logic clk, arst_n, four_wire, sclk, ce, host_sdi, serial_out_pin, oe, conv, wire_in;
  logic [11:0] sensor;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc;
  assign wire_in = (!four_wire && oe) ? serial_out_pin : host_sdi;
  str_host_model i_host (.o_sclk(sclk), .o_ce(ce), .o_sdi(host_sdi), .i_rx(four_wire ? serial_out_pin : wire_in),
    .i_four_wire(four_wire));
  str_top #(.CONV_BASE_CYCLES(BASE)) i_dut (.i_core_clk(clk), .i_arst_n(arst_n), .i_link_sclk(sclk),
    .i_chip_enable(ce), .i_link_type_select(four_wire), .i_serial_in_pin(wire_in), .o_serial_out_pin(serial_out_pin),
    .o_serial_out_oe(oe), .i_sensor_temp(sensor), .o_converting(conv));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // May miss a cycle or two if the conversion began before the call
  task automatic conv_len(output int len);
    len = 0;
    cyc = 0;
    while (conv !== 1'b1 && cyc < 400) @(posedge clk) #1 cyc++;
    while (conv === 1'b1 && len < 2000) @(posedge clk) #1 len++;
    if (cyc >= 400 || len >= 2000) begin
      error_cnt++;
      print_verdict();
    end
  endtask
  initial begin
    int len;
    logic [7:0] mask;
    arst_n = 1'b0;
    four_wire = 1'b1;
    sensor = 12'hF5E;
    repeat (4) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (2) @(posedge clk);
    i_host.frame(8'h00, 8'h00, 1);
    check(i_host.rd[0], 8'hE3, "config at reset");
    for (int m = 1; m >= 0; m--) begin
      @(posedge clk) #1 four_wire = m[0];
      for (int r = 0; r < 5; r++) begin
        i_host.frame(8'h80, 8'hF1 | 8'(r << 1), 1);
        conv_len(len);
        check(8'(len + 6 >= (BASE << r) && len <= (BASE << r) + 3), 8'h01, "conversion length");
        mask = 8'hF0 << (4 - r);
        i_host.frame(8'h01, 8'h00, 2);
        check(i_host.rd[0], 8'hE0 & mask, "low byte");
        check(i_host.rd[1], 8'hF5, "high byte");
        i_host.frame(8'h00, 8'h00, 1);
        check(i_host.rd[0], 8'hE1 | 8'(r << 1), "config after one-shot");
      end
      $display("one-shot test done, four_wire %0d", m);
    end
    @(posedge clk) #1 sensor = 12'hFF8;
    i_host.frame(8'h80, 8'hE2, 1);
    repeat (4 * BASE) @(posedge clk);
    i_host.frame(8'h01, 8'h00, 2);
    check(i_host.rd[0], 8'h80, "continuous low byte");
    check(i_host.rd[1], 8'hFF, "continuous high byte");
    @(posedge clk) #1 sensor = 12'h191;
    i_host.frame(8'h80, 8'hF2, 1);
    i_host.frame(8'h00, 8'h00, 1);
    check(i_host.rd[0], 8'hE2, "single ignored in continuous");
    repeat (2 * BASE + 10) @(posedge clk);
    i_host.frame(8'h80, 8'hE3, 1);
    repeat (3 * BASE) @(posedge clk);
    check({7'h00, conv}, 8'h00, "idle after shutdown");
    i_host.frame(8'h81, 8'h55, 1);
    i_host.frame(8'h01, 8'h00, 2);
    check(i_host.rd[0], 8'h00, "low byte after shutdown");
    check(i_host.rd[1], 8'h19, "high byte after shutdown");
    $display("continuous test done");
    print_verdict();
  end
endmodule
